// ### hdl/nfs_pkg.sv
// Purpose: Constants for the NAND flash command sequencer (host side)
// Assumes: 8-bit parallel NAND die, 50 MHz controller clock
// Notes: Device status byte layout and command codes live here
package nfs_pkg;
  localparam logic [7:0] CMD_READ       = 8'h00;
  localparam logic [7:0] CMD_READ_CONF  = 8'h30;
  localparam logic [7:0] CMD_CACHE_RD   = 8'h31;
  localparam logic [7:0] CMD_CACHE_LAST = 8'h3F;
  localparam logic [7:0] CMD_IDENT      = 8'h90;
  localparam logic [7:0] CMD_STATUS     = 8'h70;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h80;
  localparam logic [7:0] CMD_COL_CHANGE = 8'h85;
  localparam logic [7:0] CMD_PROG_CONF  = 8'h10;
  localparam logic [7:0] CMD_CACHE_PROG = 8'h15;
  localparam logic [7:0] CMD_RESET      = 8'hFF;
  localparam logic [7:0] CMD_DIE_STATUS = 8'h78;
  // Row address bit that picks the die; plain default
  localparam int DIE_ROW_BIT = 18;
  // Status byte bit positions
  localparam int ST_FAIL   = 0;
  localparam int ST_FAIL_P = 1;
  localparam int ST_ARRAY  = 5;
  localparam int ST_CACHE  = 6;
  localparam int ST_WP_N   = 7;
  // Host register offsets
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_ADDR   = 4'h1;
  localparam logic [3:0] REG_WDATA  = 4'h2;
  localparam logic [3:0] REG_RDATA  = 4'h3;
  localparam logic [3:0] REG_STATE  = 4'h4;
  localparam logic [3:0] REG_CNT    = 4'h5;
  // Control register opcode values
  localparam logic [3:0] OP_CMD  = 4'h1;
  localparam logic [3:0] OP_ADDR = 4'h2;
  localparam logic [3:0] OP_DIN  = 4'h3;
  localparam logic [3:0] OP_DOUT = 4'h4;
  localparam int ADDR_CYCLES = 5;
  localparam int ID_BYTES    = 5;
  localparam int MAX_PARTIAL = 4;
  localparam int PAGES_PER_BLK = 64;
  // Pin timing, ns, rounded up at clock rate
  localparam int CLK_NS      = 20;
  localparam int T_STROBE_NS = 30;
  localparam int T_STROBE_CYC = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_WB_NS     = 100;
  localparam int T_WB_CYC    = (T_WB_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] RESET_DATA = 8'h00;
  typedef enum logic [4:0] {
    NFS_IDLE  = 5'b00001,
    NFS_LOW   = 5'b00010,
    NFS_HIGH  = 5'b00100,
    NFS_WAITB = 5'b01000,
    NFS_DONE  = 5'b10000
  } nfs_state_e;
endpackage

// ### hdl/nfs_host.sv
// Purpose: Host sequencer driving a NAND die cycle by cycle
// Assumes: Software composes command sequences one cycle at a time
// Notes: Pins are synchronous; the busy pin is sampled directly
//
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/1ns
module nfs_host
  import nfs_pkg::*;
#(
  parameter int STROBE_CYC = T_STROBE_CYC,
  parameter int WB_CYC     = T_WB_CYC
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Software port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // NAND pins
  output logic            chip_select_n,
  output logic            cmd_latch,
  output logic            addr_latch,
  output logic            write_strobe_n,
  output logic            read_strobe_n,
  output logic            write_protect_n,
  input  wire logic       ready_busy_n,
  input  wire logic [7:0] io_in,
  output logic      [7:0] io_out,
  output logic            io_oe
);

  nfs_state_e st_r;
  logic [3:0] op_r;
  logic [7:0] dout_r;
  logic [7:0] din_r;
  logic [7:0] cnt_r;
  logic [7:0] addr_cnt_r;
  logic       err_r;
  logic       wp_en_r;
  logic       wait_rb_r;
  logic [7:0] last_cmd_r;

  logic start;
  logic is_read;
  logic busy_cmd;
  // A new cache read may start before the page has been drained
  assign start   = reg_wr && (reg_addr == REG_CTRL) && (st_r == NFS_IDLE);
  assign is_read = (op_r == OP_DOUT);

  // Of command cycles, only status, die status and reset may start while the die is busy
  // Per-die status stays legal so a shared select can pick its reporter
  assign busy_cmd = (reg_wdata[3:0] == OP_CMD) && !ready_busy_n &&
                    (dout_r != CMD_STATUS) && (dout_r != CMD_RESET) &&
                    (dout_r != CMD_DIE_STATUS);

  // Strobe sequencer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= NFS_IDLE;
      cnt_r <= 8'h00;
      op_r <= 4'h0;
      wait_rb_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      // Clear first so a refusal in the same cycle still sets
      if (reg_wr && reg_addr == REG_STATE && reg_wdata[0]) begin
        err_r <= 1'b0;
      end
      case (st_r)
        NFS_IDLE: begin
          if (start) begin
            if (busy_cmd) begin
              err_r <= 1'b1;
            end else begin
              op_r <= reg_wdata[3:0];
              wait_rb_r <= reg_wdata[4];
              cnt_r <= STROBE_CYC[7:0];
              st_r <= NFS_LOW;
            end
          end
        end
        NFS_LOW: begin
          if (cnt_r <= 8'h01) begin
            cnt_r <= STROBE_CYC[7:0];
            st_r <= NFS_HIGH;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        NFS_HIGH: begin
          if (cnt_r <= 8'h01) begin
            cnt_r <= WB_CYC[7:0];
            st_r <= wait_rb_r ? NFS_WAITB : NFS_DONE;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        NFS_WAITB: begin
          // Busy may rise late, so ignore the pin until the window passes
          if (cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01;
          end else if (ready_busy_n) begin
            st_r <= NFS_DONE;
          end
        end
        NFS_DONE: st_r <= NFS_IDLE;
        default: st_r <= NFS_IDLE;
      endcase
    end
  end

  // Command tracking and data registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dout_r <= RESET_DATA;
      din_r <= RESET_DATA;
      last_cmd_r <= CMD_READ;
      addr_cnt_r <= 8'h00;
      wp_en_r <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == REG_WDATA) begin
        dout_r <= reg_wdata;
      end
      if (reg_wr && reg_addr == REG_STATE) begin
        wp_en_r <= reg_wdata[1];
      end
      if (st_r == NFS_HIGH && cnt_r == STROBE_CYC[7:0]) begin
        if (op_r == OP_CMD) begin
          last_cmd_r <= dout_r;
          addr_cnt_r <= 8'h00;
        end
        if (op_r == OP_ADDR) begin
          addr_cnt_r <= addr_cnt_r + 8'h01;
        end
      end
      // Sample on the strobe's rising edge
      if (is_read && st_r == NFS_LOW && cnt_r <= 8'h01) begin
        din_r <= io_in;
      end
    end
  end

  // Program order guard
  // Software owns page order; this only flags a breach and never blocks
  // Limitation: erase is outside this block, so counts reset on a page change
  // Flags read back in STATE bits 7:5 and clear with the error bit
  localparam int PAGE_BITS = $clog2(PAGES_PER_BLK);
  localparam int ROW_BITS  = 24;
  localparam int N_SEQ     = 3;

  logic [7:0]          addr_byte_r [ADDR_CYCLES];
  logic [ROW_BITS-1:0] row;
  logic [ROW_BITS-1:0] last_row_r;
  logic                have_row_r;
  logic [2:0]          partial_r;
  logic                in_prog_r;
  logic                cache_seq_r;
  // Bits of the breach flags: 0 order, 1 partial count, 2 die
  logic [N_SEQ-1:0]    seq_err_r;
  logic [N_SEQ-1:0]    seq_bad;

  // Strobe commit decode
  logic                commit;
  logic                addr_commit;
  logic                cmd_commit;
  logic                confirm;
  logic                same_block;
  logic                same_page;
  logic                seq_clr;

  // One strobe cycle is committed on its first high phase cycle
  assign commit      = (st_r == NFS_HIGH) && (cnt_r == STROBE_CYC[7:0]);
  assign addr_commit = commit && (op_r == OP_ADDR);
  assign cmd_commit  = commit && (op_r == OP_CMD);
  // Only a confirm inside an open program counts
  assign confirm     = cmd_commit && in_prog_r &&
                       ((dout_r == CMD_PROG_CONF) || (dout_r == CMD_CACHE_PROG));
  // One write clears the refusal and all breach flags
  assign seq_clr     = reg_wr && (reg_addr == REG_STATE) && reg_wdata[0];

  // Row address is carried by the last three address cycles
  // Block and page split at the page-count boundary
  assign row = {addr_byte_r[4], addr_byte_r[3], addr_byte_r[2]};
  assign same_block = have_row_r &&
                      (row[ROW_BITS-1:PAGE_BITS] == last_row_r[ROW_BITS-1:PAGE_BITS]);
  assign same_page  = same_block && (row[PAGE_BITS-1:0] == last_row_r[PAGE_BITS-1:0]);

  // Going back inside a block is the breach; a new block restarts the order
  assign seq_bad[0] = same_block && (row[PAGE_BITS-1:0] < last_row_r[PAGE_BITS-1:0]);
  // Fifth program of one page without an erase in between
  assign seq_bad[1] = same_page && (partial_r >= 3'(MAX_PARTIAL));
  // A cached run must stay on one die
  assign seq_bad[2] = cache_seq_r && (row[DIE_ROW_BIT] != last_row_r[DIE_ROW_BIT]);

  // Address byte capture, indexed by the cycle count since the command
  // Address bytes beyond the fifth match no index and are dropped
  genvar g;
  generate
    for (g = 0; g < ADDR_CYCLES; g++) begin : g_addr
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          addr_byte_r[g] <= 8'h00;
        end else if (addr_commit && (addr_cnt_r == 8'(g))) begin
          addr_byte_r[g] <= dout_r;
        end
      end
    end
  endgenerate

  // Open from setup to confirm; a column change keeps it open
  // Any other command in between drops the window
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      in_prog_r <= 1'b0;
    end else if (cmd_commit) begin
      in_prog_r <= (dout_r == CMD_PROG_SETUP) ||
                   (in_prog_r && (dout_r == CMD_COL_CHANGE));
    end
  end

  // Page of the last confirmed program
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      last_row_r <= '0;
      have_row_r <= 1'b0;
    end else if (confirm) begin
      last_row_r <= row;
      have_row_r <= 1'b1;
    end
  end

  // Saturates so a long run of partials cannot wrap back to legal
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      partial_r <= 3'h0;
    end else if (confirm) begin
      if (!same_page) begin
        partial_r <= 3'h1;
      end else if (partial_r != 3'h7) begin
        partial_r <= partial_r + 3'h1;
      end
    end
  end

  // Ending on 10h closes a cached run, which a pin-only host must do
  // Die check only applies between pages of one cached run
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cache_seq_r <= 1'b0;
    end else if (confirm) begin
      cache_seq_r <= (dout_r == CMD_CACHE_PROG);
    end
  end

  // Sticky breach flags; a set beats a clear in the same cycle
  generate
    for (g = 0; g < N_SEQ; g++) begin : g_seq
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          seq_err_r[g] <= 1'b0;
        end else if (confirm && seq_bad[g]) begin
          seq_err_r[g] <= 1'b1;
        end else if (seq_clr) begin
          seq_err_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Pin drive
  always_comb begin
    chip_select_n = (st_r == NFS_IDLE) && (last_cmd_r != CMD_STATUS);
    cmd_latch = (op_r == OP_CMD) && (st_r == NFS_LOW || st_r == NFS_HIGH);
    addr_latch = (op_r == OP_ADDR) && (st_r == NFS_LOW || st_r == NFS_HIGH);
    write_strobe_n = !((st_r == NFS_LOW) && !is_read);
    read_strobe_n = !((st_r == NFS_LOW) && is_read);
    write_protect_n = !wp_en_r;
    io_out = dout_r;
    io_oe = !is_read && (st_r == NFS_LOW || st_r == NFS_HIGH);
  end

  // Register read
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_WDATA: reg_rdata <= dout_r;
        REG_RDATA: reg_rdata <= din_r;
        // Breach flags sit in the top three bits
        REG_STATE: reg_rdata <= {seq_err_r, err_r, ready_busy_n, wp_en_r,
                                 (st_r != NFS_IDLE), (st_r == NFS_DONE)};
        REG_CNT: reg_rdata <= addr_cnt_r;
        REG_CTRL: reg_rdata <= last_cmd_r;
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // nfs_host

// ### verification/nfs_host_checker.sv
// Purpose: Pin checker for nfs_host
// Assumes: STROBE_CYC of 2
// Notes: Bound after the module
`timescale 1ns/1ns
module nfs_host_checker
  import nfs_pkg::*;
(
  input wire logic       clk, nrst, reg_wr, reg_rd, cmd_latch, addr_latch, io_oe,
  input wire logic       chip_select_n, write_strobe_n, read_strobe_n, write_protect_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata, reg_rdata, io_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_we; !write_strobe_n ##1 write_strobe_n; endsequence
  sequence s_re; !read_strobe_n ##1 read_strobe_n; endsequence
  property p_we; $fell(write_strobe_n) |=> s_we; endproperty
  property p_re; $fell(read_strobe_n) |=> s_re; endproperty
  property p_lat; !(cmd_latch && addr_latch); endproperty
  property p_oe; !read_strobe_n |-> !io_oe && !chip_select_n; endproperty
  property p_cmd; $rose(cmd_latch) |-> $past(reg_wr) && $past(reg_addr) == REG_CTRL; endproperty
  property p_rd; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  property p_wp; reg_wr && reg_addr == REG_STATE |=> write_protect_n == !$past(reg_wdata[1]);
  endproperty
  property p_io; reg_wr && reg_addr == REG_WDATA |=> io_out == $past(reg_wdata); endproperty
  a_we: assert property (p_we) else $error("write strobe width");
  a_re: assert property (p_re) else $error("read strobe width");
  a_lat: assert property (p_lat) else $error("both latches");
  a_oe: assert property (p_oe) else $error("bus driven in read");
  a_cmd: assert property (p_cmd) else $error("stray command");
  a_rd: assert property (p_rd) else $error("read data out of slot");
  a_wp: assert property (p_wp) else $error("protect pin");
  a_io: assert property (p_io) else $error("bus byte");
endmodule // nfs_host_checker
bind nfs_host nfs_host_checker chk_u (.clk, .nrst, .reg_wr, .reg_rd, .cmd_latch, .addr_latch,
  .io_oe, .chip_select_n, .write_strobe_n, .read_strobe_n, .write_protect_n, .reg_addr,
  .reg_wdata, .reg_rdata, .io_out);

// ### verification/nfs_nand_model.sv
// Purpose: Behavioural NAND die
// Assumes: Strobes move on clock edges
// Notes: No page storage; read data is the column count
`timescale 1ns/1ns
module nfs_nand_model
  import nfs_pkg::*;
#(
  parameter logic [7:0] MAKER_ID = 8'h5A, // Arbitrary value
  parameter logic [7:0] DEV_ID   = 8'hA5, // Arbitrary value
  parameter int         T_BUSY   = 100
) (
  input  wire logic       clk, cs_n, cle, ale, we_n, re_n, wp_n,
  input  wire logic [7:0] din,
  output logic            rb_n,
  output logic      [7:0] dq
);
  logic [7:0] mode = CMD_READ, idx = '0, last = '0, d_q, val;
  logic       c_q, a_q, we_q = 1, re_q = 1;
  int         busy = 0;
  assign rb_n = (busy == 0);
  // Released bus shows a toggling pattern, not the last byte
  assign dq = (!cs_n && !re_n) ? val : ~last;
  always_comb begin
    case (mode)
      CMD_STATUS: val = {wp_n, rb_n, rb_n, 5'h00};
      CMD_IDENT: val = idx == 0 ? MAKER_ID : idx == 1 ? DEV_ID : idx == 2 ? 8'h90
        : idx == 3 ? 8'h95 : 8'h54;
      default: val = idx;
    endcase
  end
  always @(posedge clk) begin
    we_q <= we_n;
    re_q <= re_n;
    last <= dq;
    if (!we_n) {c_q, a_q, d_q} <= {cle, ale, din};
    if (re_n && !re_q) idx <= idx + 8'h01;
    if (busy > 0) busy <= busy - 1;
    if (we_n && !we_q && a_q) idx <= '0;
    if (we_n && !we_q && c_q && (rb_n || d_q == CMD_STATUS || d_q == CMD_RESET)) begin
      mode <= d_q;
      idx <= '0;
      if (d_q == CMD_READ_CONF || d_q == CMD_PROG_CONF) busy <= T_BUSY;
      if (d_q == CMD_CACHE_RD || d_q == CMD_CACHE_LAST) busy <= 4;
      if (d_q == CMD_CACHE_PROG) busy <= 4;
    end
  end
endmodule // nfs_nand_model

// ### verification/nand_cache_read_program_status_tb.sv
// Purpose: Self-checking bench for nfs_host
// Assumes: Model busy of 100 cycles
// Notes: Random bytes feed data cycles and the first program's address cycles
`timescale 1ns/1ns
module nand_cache_read_program_status_tb;
  import nfs_pkg::*;
  logic clk = 0, nrst, reg_wr, reg_rd, cs_n, cle, ale, we_n, re_n, wp_n, rb_n, oe;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, dq, io_out, v;
  int error_cnt = 0, checks = 0, i;
  always #10 clk = ~clk;
  nfs_host dut_u (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .chip_select_n(cs_n), .cmd_latch(cle), .addr_latch(ale), .write_strobe_n(we_n),
    .read_strobe_n(re_n), .write_protect_n(wp_n), .ready_busy_n(rb_n), .io_in(dq),
    .io_out, .io_oe(oe));
  nfs_nand_model dev_u (.clk, .cs_n, .cle, .ale, .we_n, .re_n, .wp_n, .din(io_out), .rb_n, .dq);
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clk) reg_wr <= 0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk) {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk) reg_rd <= 0;
    #1 d = reg_rdata;
  endtask
  task automatic op(input logic w, input logic [3:0] o, input logic [7:0] b);
    logic [7:0] s;
    wr(REG_WDATA, b);
    wr(REG_CTRL, {3'b000, w, o});
    for (int n = 0; n < 300; n++) begin
      rd(REG_STATE, s);
      if (!s[1]) break;
    end
    if (s[1]) chk("op done", 8'h00, {7'h00, s[1]});
  endtask
  task automatic prog(input logic [7:0] pg);
    op(0, OP_CMD, CMD_PROG_SETUP);
    for (int n = 0; n < ADDR_CYCLES; n++) op(0, OP_ADDR, n == 2 ? pg : 8'h00);
    op(0, OP_DIN, 8'($urandom));
    op(1, OP_CMD, CMD_PROG_CONF);
  endtask
  task automatic dout(output logic [7:0] d);
    op(0, OP_DOUT, 8'h00);
    rd(REG_RDATA, d);
  endtask
  task automatic chk(input string nm, input logic [7:0] e, g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [7:0] st_exp(input logic wp, rdy);
    return {!wp, rdy, rdy, 5'h00};
  endfunction
  task automatic close_out;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd, nrst} = '0;
    void'($urandom(32'he6f4));
    repeat (20) @(posedge clk);
    nrst <= 1;
    op(0, OP_CMD, CMD_IDENT);
    op(0, OP_ADDR, 8'h00);
    for (i = 0; i < ID_BYTES; i++) begin
      dout(v);
      chk("id", i == 0 ? 8'h5A : i == 1 ? 8'hA5 : i == 2 ? 8'h90 : i == 3 ? 8'h95 : 8'h54, v);
    end
    op(0, OP_CMD, CMD_STATUS);
    dout(v);
    chk("status", st_exp(0, 1), v);
    wr(REG_STATE, 8'h02);
    dout(v);
    chk("wp status", st_exp(1, 1), v);
    wr(REG_STATE, 8'h00);
    op(0, OP_CMD, CMD_PROG_SETUP);
    repeat (ADDR_CYCLES) op(0, OP_ADDR, 8'($urandom));
    rd(REG_CNT, v);
    chk("addr count", 8'(ADDR_CYCLES), v);
    repeat (3) op(0, OP_DIN, 8'($urandom));
    op(0, OP_CMD, CMD_PROG_CONF);
    op(0, OP_CMD, CMD_STATUS);
    dout(v);
    chk("busy status", st_exp(0, 0), v);
    op(0, OP_CMD, CMD_READ);
    rd(REG_STATE, v);
    chk("refused", 8'h01, {7'h00, v[4]});
    wr(REG_STATE, 8'h01);
    for (i = 0; i < 100 && !v[6]; i++) dout(v);
    chk("live status", st_exp(0, 1), v);
    op(0, OP_CMD, CMD_READ);
    repeat (ADDR_CYCLES) op(0, OP_ADDR, 8'h00);
    op(1, OP_CMD, CMD_READ_CONF);
    for (i = 0; i < 2; i++) begin
      dout(v);
      chk("page data", 8'(i), v);
    end
    op(0, OP_CMD, CMD_STATUS);
    dout(v);
    op(0, OP_CMD, CMD_READ);
    dout(v);
    chk("restart", 8'h00, v);
    for (i = 0; i < 2; i++) begin
      op(1, OP_CMD, i ? CMD_CACHE_LAST : CMD_CACHE_RD);
      rd(REG_CTRL, v);
      chk("cache cmd", i ? CMD_CACHE_LAST : CMD_CACHE_RD, v);
    end
    prog(8'h05);
    wr(REG_STATE, 8'h01);
    prog(8'h05);
    rd(REG_STATE, v);
    chk("partial ok", 8'h00, {7'h00, v[6] | v[5]});
    prog(8'h03);
    rd(REG_STATE, v);
    chk("page order", 8'h01, {7'h00, v[5]});
    close_out();
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    close_out();
  end
endmodule // nand_cache_read_program_status_tb
